// ===== design/pin_override_defines.svh
// constants for the pin output override timer
`ifndef PIN_OVERRIDE_DEFINES_SVH
`define PIN_OVERRIDE_DEFINES_SVH

`define NUM_PINS          20
`define NUM_PINS_THT      15
`define CLK_PERIOD_NS     8
`define TICK_PERIOD_MS    100
`define TICK_CYCLES       ((`TICK_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)
`define TIMER_MAX         16'h1770
`define CFG_OUT_LOW       3'h4
`define CFG_OUT_HIGH      3'h5
`define CFG_RESET         3'h0

`define ADDR_LEVEL        8'h00
`define ADDR_MASK         8'h04
`define ADDR_STATUS       8'h08
`define ADDR_PIN_OUT      8'h0C
`define ADDR_ACTIVE       8'h10
`define ADDR_CFG_BASE     8'h20
`define ADDR_TIMER_BASE   8'h80
`define ADDR_TIMER_END    8'hCF

`define ST_REJECT_BIT     0
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`define PIN_MASK_ALL      20'hFFFFF

`endif

// ===== design/pin_override_pkg.sv
// types for the pin output override timer
`default_nettype none
package pin_override_pkg;
	typedef logic [19:0] pin_vec_t;
	typedef logic [15:0] timer_val_t;
	typedef logic [2:0]  pin_cfg_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} wr_req_t;

	typedef enum logic [3:0] {
		WR_IDLE = 4'h1,
		WR_EXEC = 4'h2,
		WR_RESP = 4'h4
	} wr_state_t;
endpackage
`default_nettype wire

// ===== design/tick_prescaler.sv
// shared 100 ms tick generator
`include "pin_override_defines.svh"
`default_nettype none
module tick_prescaler
	import pin_override_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	output logic      tick
);
	logic [23:0] count;
	wire         wrap = (count == 24'(TICK_CYCLES - 1));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= 24'h000000;
			tick  <= 1'b0;
		end else begin
			count <= wrap ? 24'h000000 : count + 24'h000001;
			tick  <= wrap;
		end
	end

	a_tick_width: assert property (@(posedge aclk) disable iff (!aresetn)
		tick |=> !tick) else $error("tick lasted more than one cycle");
endmodule
`default_nettype wire

// ===== design/pin_revert_counter.sv
// one pin's revert countdown
`include "pin_override_defines.svh"
`default_nettype none
module pin_revert_counter
	import pin_override_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       load,
	input  wire timer_val_t setting,
	input  wire logic       tick,
	output logic            expire
);
	timer_val_t remain;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			remain <= 16'h0000;
			expire <= 1'b0;
		end else if (load) begin
			remain <= setting;
			expire <= 1'b0;
		end else begin
			expire <= tick && (remain == 16'h0001);
			if (tick && remain != 16'h0000)
				remain <= remain - 16'h0001;
		end
	end
endmodule
`default_nettype wire

// ===== design/pin_output_override_timer.sv
// timed output override for twenty general-purpose pins, AXI4-Lite slave
// Notes on behaviour
// - the level command is a bitmap where bit n gives the level for pin n, bits 0 to 19.
// - bits 15 to 19 only reach real pins on the surface-mount variant.
// - a level bit is applied only where the matching override mask bit is 1.
// - an override acts only on pins configured as output low (4) or output high (5).
// - a level bit of 0 drives the pin low and 1 drives it high.
// - with a zero timer the override holds until the next level command, reset, or until the pin is configured as a non-output.
// - with a non-zero timer the override holds that many 100 ms periods, then reverts.
// - timer settings above 6000 are rejected.
// - the countdown runs only for pins whose commanded level differs from the configured one.
// - there is one timer per pin, twenty in all, each with its own setting register.
// - after reset no pin is an output, so level commands do nothing until configured.
`include "pin_override_defines.svh"
`default_nettype none
module pin_output_override_timer
	import pin_override_pkg::*;
#(
	parameter int unsigned TICK_CYCLES   = `TICK_CYCLES,
	parameter bit          SURFACE_MOUNT = 1'b1
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output pin_vec_t         pin_out,
	output pin_vec_t         pin_oe
);
	// register state
	pin_vec_t   level_cmd;
	pin_vec_t   output_override_mask;
	pin_vec_t   override_active;
	pin_cfg_t   pin_cfg [`NUM_PINS];
	timer_val_t revert_timer [`NUM_PINS];
	logic       timer_reject;

	// write channel capture
	wr_state_t  wr_state;
	logic       aw_held;
	logic       w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wr_req_t    req;

	assign req = '{addr: aw_addr, data: w_data, strb: w_strb};

	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take  = s_axi_wvalid && s_axi_wready;
	wire do_exec = (wr_state == WR_EXEC);

	// write decode
	wire wr_level  = do_exec && req.addr == `ADDR_LEVEL;
	wire wr_mask   = do_exec && req.addr == `ADDR_MASK;
	wire wr_status = do_exec && req.addr == `ADDR_STATUS;
	wire wr_cfg_rg = do_exec && req.addr >= `ADDR_CFG_BASE
		&& req.addr < (`ADDR_CFG_BASE + 8'(`NUM_PINS * 4));
	wire wr_tmr_rg = do_exec && req.addr >= `ADDR_TIMER_BASE
		&& req.addr <= `ADDR_TIMER_END;
	wire [4:0] wr_idx = wr_cfg_rg ? 5'((req.addr - `ADDR_CFG_BASE) >> 2)
		: 5'((req.addr - `ADDR_TIMER_BASE) >> 2);
	wire wr_known  = wr_level || wr_mask || wr_status || wr_cfg_rg || wr_tmr_rg
		|| req.addr == `ADDR_PIN_OUT || req.addr == `ADDR_ACTIVE;
	// whole word compared so upper bits cannot sneak a big value past the limit
	wire tmr_bad   = req.data > {16'h0000, `TIMER_MAX};
	wire bad_write = !wr_known || (wr_tmr_rg && tmr_bad);

	// pins that physically exist on this variant
	wire pin_vec_t present = SURFACE_MOUNT ? `PIN_MASK_ALL
		: pin_vec_t'((1 << `NUM_PINS_THT) - 1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state <= WR_IDLE;
			aw_held  <= 1'b0;
			w_held   <= 1'b0;
			aw_addr  <= 8'h00;
			w_data   <= 32'h00000000;
			w_strb   <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
		end else begin
			unique case (wr_state)
				WR_IDLE: begin
					if (aw_take) begin
						aw_held <= 1'b1;
						aw_addr <= {s_axi_awaddr[7:2], 2'b00};
						s_axi_awready <= 1'b0;
					end
					if (w_take) begin
						w_held <= 1'b1;
						w_data <= s_axi_wdata;
						w_strb <= s_axi_wstrb;
						s_axi_wready <= 1'b0;
					end
					if ((aw_held || aw_take) && (w_held || w_take))
						wr_state <= WR_EXEC;
				end
				WR_EXEC: begin
					s_axi_bvalid <= 1'b1;
					s_axi_bresp  <= bad_write ? `RESP_SLVERR : `RESP_OKAY;
					wr_state     <= WR_RESP;
				end
				WR_RESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						aw_held      <= 1'b0;
						w_held       <= 1'b0;
						s_axi_awready <= 1'b1;
						s_axi_wready  <= 1'b1;
						wr_state     <= WR_IDLE;
					end
				end
			endcase
		end
	end

	// ready flags are registered: low from capture until the response is taken

	// command and mask registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_cmd            <= 20'h00000;
			output_override_mask <= 20'h00000;
			timer_reject         <= 1'b0;
		end else begin
			if (wr_level)
				level_cmd <= req.data[19:0];
			if (wr_mask)
				output_override_mask <= req.data[19:0];
			// reject flag: set wins over clear
			if (wr_tmr_rg && tmr_bad)
				timer_reject <= 1'b1;
			else if (wr_status && req.data[`ST_REJECT_BIT])
				timer_reject <= 1'b0;
		end
	end

	wire tick;
	tick_prescaler #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (tick)
	);

	pin_vec_t is_output;
	pin_vec_t cfg_level;
	pin_vec_t cmd_hit;
	pin_vec_t expire;

	genvar g;
	generate
		for (g = 0; g < `NUM_PINS; g++) begin : g_pin
			// each of the 20 pins has its own timer setting and countdown
			assign is_output[g] = pin_cfg[g] == `CFG_OUT_LOW
				|| pin_cfg[g] == `CFG_OUT_HIGH;
			assign cfg_level[g] = pin_cfg[g] == `CFG_OUT_HIGH;
			assign cmd_hit[g]   = wr_level && req.data[g] && 1'b1
				&& output_override_mask[g] && is_output[g] && present[g]
				|| wr_level && !req.data[g] && output_override_mask[g]
				&& is_output[g] && present[g];

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pin_cfg[g]      <= `CFG_RESET;
					revert_timer[g] <= 16'h0000;
				end else begin
					if (wr_cfg_rg && wr_idx == 5'(g))
						pin_cfg[g] <= req.data[2:0];
					if (wr_tmr_rg && wr_idx == 5'(g) && !tmr_bad)
						revert_timer[g] <= req.data[15:0];
				end
			end

			pin_revert_counter u_cnt (
				.aclk    (aclk),
				.aresetn (aresetn),
				// equal level loads zero, so no stale countdown keeps running
				.load    (cmd_hit[g]),
				.setting ((req.data[g] != cfg_level[g]) ? revert_timer[g] : 16'h0000),
				.tick    (tick),
				.expire  (expire[g])
			);

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					override_active[g] <= 1'b0;
					pin_out[g]         <= 1'b0;
					pin_oe[g]          <= 1'b0;
				end else begin
					if (cmd_hit[g])
						override_active[g] <= 1'b1;
					else if (!is_output[g] || (expire[g] && revert_timer[g] != 16'h0000))
						override_active[g] <= 1'b0;
					pin_oe[g] <= is_output[g] && present[g];
					if (cmd_hit[g])
						pin_out[g] <= req.data[g];
					else if (override_active[g] && !expire[g] && is_output[g])
						pin_out[g] <= pin_out[g];
					else
						pin_out[g] <= cfg_level[g];
				end
			end
		end
	endgenerate

	// read side
	wire [4:0] rd_idx_c = 5'((s_axi_araddr - `ADDR_CFG_BASE) >> 2);
	wire [4:0] rd_idx_t = 5'((s_axi_araddr - `ADDR_TIMER_BASE) >> 2);
	wire rd_cfg = s_axi_araddr >= `ADDR_CFG_BASE
		&& s_axi_araddr < (`ADDR_CFG_BASE + 8'(`NUM_PINS * 4));
	wire rd_tmr = s_axi_araddr >= `ADDR_TIMER_BASE && s_axi_araddr <= `ADDR_TIMER_END;
	logic [31:0] rd_mux;
	logic        rd_ok;
	always_comb begin
		rd_mux = 32'h00000000;
		rd_ok  = 1'b1;
		unique case ({s_axi_araddr[7:2], 2'b00})
			`ADDR_LEVEL:   rd_mux = {12'h000, level_cmd};
			`ADDR_MASK:    rd_mux = {12'h000, output_override_mask};
			`ADDR_STATUS:  rd_mux = {31'h00000000, timer_reject};
			`ADDR_PIN_OUT: rd_mux = {12'h000, pin_out};
			`ADDR_ACTIVE:  rd_mux = {12'h000, override_active};
			default: begin
				if (rd_cfg)
					rd_mux = {29'h00000000, pin_cfg[rd_idx_c]};
				else if (rd_tmr)
					rd_mux = {16'h0000, revert_timer[rd_idx_t]};
				else
					rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
			s_axi_arready <= 1'b1;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end else if (s_axi_arvalid) begin
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mux;
			s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			s_axi_arready <= 1'b0;
		end
	end

	property p_reject_large;
		@(posedge aclk) disable iff (!aresetn)
		(wr_tmr_rg && tmr_bad) |=> timer_reject && $stable(revert_timer[0]);
	endproperty
	a_reject_large: assert property (p_reject_large) else $error("big timer value kept");

	property p_level_drive;
		@(posedge aclk) disable iff (!aresetn)
		cmd_hit[0] |=> pin_out[0] == $past(req.data[0]);
	endproperty
	a_level_drive: assert property (p_level_drive) else $error("pin 0 level wrong");

	property p_mask_gate;
		@(posedge aclk) disable iff (!aresetn)
		(wr_level && !output_override_mask[1]) |-> !cmd_hit[1];
	endproperty
	a_mask_gate: assert property (p_mask_gate) else $error("masked pin overridden");

	property p_cfg_gate;
		@(posedge aclk) disable iff (!aresetn)
		!is_output[2] |=> !pin_oe[2] && !override_active[2];
	endproperty
	a_cfg_gate: assert property (p_cfg_gate) else $error("non-output pin driven");

	property p_variant;
		@(posedge aclk) disable iff (!aresetn)
		!SURFACE_MOUNT |-> !pin_oe[15] && !cmd_hit[19];
	endproperty
	a_variant: assert property (p_variant) else $error("absent pin driven");

	property p_bit_map;
		@(posedge aclk) disable iff (!aresetn)
		wr_level |=> level_cmd == $past(req.data[19:0]);
	endproperty
	a_bit_map: assert property (p_bit_map) else $error("level bitmap not stored");

	property p_hold_zero;
		@(posedge aclk) disable iff (!aresetn)
		(override_active[0] && revert_timer[0] == 16'h0000 && !wr_level && is_output[0])
			|=> override_active[0];
	endproperty
	a_hold_zero: assert property (p_hold_zero) else $error("untimed override lost");

	property p_revert;
		@(posedge aclk) disable iff (!aresetn)
		(expire[0] && revert_timer[0] != 16'h0000 && !cmd_hit[0])
			|=> !override_active[0] ##1 pin_out[0] == cfg_level[0];
	endproperty
	a_revert: assert property (p_revert) else $error("pin did not revert");
endmodule
`default_nettype wire

// ===== testbench/pin_output_override_timer_bench.sv
// self-checking bench for the pin output override timer
`include "pin_override_defines.svh"
`default_nettype none
module pin_output_override_timer_bench import pin_override_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// short tick so revert periods fit in a few dozen cycles
	localparam int unsigned TICKS = 10;

	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata = 32'h0;
	logic        wvalid = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready = 1'b0;
	logic [7:0]  araddr = 8'h00;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready = 1'b0;
	pin_vec_t    pin_out;
	pin_vec_t    pin_oe;
	pin_vec_t    pin_out_tht;
	pin_vec_t    pin_oe_tht;
	int          err_count = 0;
	int          comparisons = 0;
	int          cycles = 0;

	always #4 aclk = ~aclk;

	pin_output_override_timer #(
		.TICK_CYCLES   (TICKS),
		.SURFACE_MOUNT (1'b1)
	) u_pin_output_override_timer (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (awaddr),
		.s_axi_awvalid (awvalid),
		.s_axi_awready (awready),
		.s_axi_wdata   (wdata),
		.s_axi_wstrb   (4'hF),
		.s_axi_wvalid  (wvalid),
		.s_axi_wready  (wready),
		.s_axi_bresp   (bresp),
		.s_axi_bvalid  (bvalid),
		.s_axi_bready  (bready),
		.s_axi_araddr  (araddr),
		.s_axi_arvalid (arvalid),
		.s_axi_arready (arready),
		.s_axi_rdata   (rdata),
		.s_axi_rresp   (rresp),
		.s_axi_rvalid  (rvalid),
		.s_axi_rready  (rready),
		.pin_out       (pin_out),
		.pin_oe        (pin_oe)
	);

	// through-hole variant on the same bus; only its pins are watched
	pin_output_override_timer #(
		.TICK_CYCLES   (TICKS),
		.SURFACE_MOUNT (1'b0)
	) u_pin_output_override_timer_tht (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (awaddr),
		.s_axi_awvalid (awvalid),
		.s_axi_awready (),
		.s_axi_wdata   (wdata),
		.s_axi_wstrb   (4'hF),
		.s_axi_wvalid  (wvalid),
		.s_axi_wready  (),
		.s_axi_bresp   (),
		.s_axi_bvalid  (),
		.s_axi_bready  (bready),
		.s_axi_araddr  (araddr),
		.s_axi_arvalid (arvalid),
		.s_axi_arready (),
		.s_axi_rdata   (),
		.s_axi_rresp   (),
		.s_axi_rvalid  (),
		.s_axi_rready  (rready),
		.pin_out       (pin_out_tht),
		.pin_oe        (pin_oe_tht)
	);

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// values read right after an edge are the pre-edge ones, so no race
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk("bresp", {30'h0, e}, {30'h0, bresp});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk("rdata", e, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask

	// levels of non-output pins are not defined, so only enabled bits count
	task automatic pins(input pin_vec_t eo, input pin_vec_t ev);
		@(posedge aclk);
		chk("pin_oe", {12'h0, eo}, {12'h0, pin_oe});
		chk("pin_out", {12'h0, ev}, {12'h0, pin_out & pin_oe});
		chk("pin_oe_tht", {12'h0, eo & 20'h07FFF}, {12'h0, pin_oe_tht});
		chk("pin_out_tht", {12'h0, ev & 20'h07FFF}, {12'h0, pin_out_tht & pin_oe_tht});
	endtask

	task automatic reset_dut();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			finish_test();
		end
	end

	initial begin
		reset_dut();
		pins(20'h0, 20'h0);
		rd(`ADDR_CFG_BASE, 32'h0, `RESP_OKAY);
		wr(`ADDR_MASK, 32'h000FFFFF, `RESP_OKAY);
		rd(`ADDR_MASK, 32'h000FFFFF, `RESP_OKAY);
		wr(`ADDR_LEVEL, 32'h000FFFFF, `RESP_OKAY);
		pins(20'h0, 20'h0);
		// second reset clears the stale command before the pins are set up
		reset_dut();
		pins(20'h0, 20'h0);
		for (int n = 0; n < 20; n++)
			wr(`ADDR_CFG_BASE + 8'(4 * n),
				(n < 18) ? (n[0] ? 32'h5 : 32'h4) : 32'h2, `RESP_OKAY);
		pins(20'h3FFFF, 20'h2AAAA);
		wr(`ADDR_MASK, 32'h000C000F, `RESP_OKAY);
		wr(`ADDR_LEVEL, 32'h000FFFF5, `RESP_OKAY);
		pins(20'h3FFFF, 20'h2AAA5);
		repeat (60) @(posedge aclk);
		pins(20'h3FFFF, 20'h2AAA5);
		wr(`ADDR_MASK, 32'h000FFFFF, `RESP_OKAY);
		wr(`ADDR_LEVEL, 32'h00000000, `RESP_OKAY);
		pins(20'h3FFFF, 20'h00000);
		wr(`ADDR_LEVEL, 32'h000FFFFF, `RESP_OKAY);
		pins(20'h3FFFF, 20'h3FFFF);
		wr(`ADDR_TIMER_BASE, 32'h1771, `RESP_SLVERR);
		wr(`ADDR_TIMER_BASE, 32'h00010004, `RESP_SLVERR);
		rd(`ADDR_TIMER_BASE, 32'h0, `RESP_OKAY);
		rd(`ADDR_STATUS, 32'h1, `RESP_OKAY);
		wr(`ADDR_STATUS, 32'h1, `RESP_OKAY);
		rd(`ADDR_STATUS, 32'h0, `RESP_OKAY);
		wr(`ADDR_TIMER_BASE, 32'h1770, `RESP_OKAY);
		rd(`ADDR_TIMER_BASE, 32'h1770, `RESP_OKAY);
		wr(`ADDR_TIMER_BASE, 32'h4, `RESP_OKAY);
		wr(`ADDR_TIMER_BASE + 8'h30, 32'h6, `RESP_OKAY);
		rd(`ADDR_TIMER_BASE + 8'h30, 32'h6, `RESP_OKAY);
		// pin 1 is commanded to its configured level, so its timer must not run
		wr(`ADDR_TIMER_BASE + 8'h04, 32'h2, `RESP_OKAY);
		// pin 0 reverts after 4 ticks, pin 12 after 6, the rest hold
		wr(`ADDR_LEVEL, 32'h000FFFFF, `RESP_OKAY);
		repeat (15) @(posedge aclk);
		pins(20'h3FFFF, 20'h3FFFF);
		repeat (30) @(posedge aclk);
		pins(20'h3FFFF, 20'h3FFFE);
		repeat (30) @(posedge aclk);
		pins(20'h3FFFF, 20'h3EFFE);
		rd(`ADDR_PIN_OUT, 32'h0003EFFE, `RESP_OKAY);
		rd(`ADDR_ACTIVE, 32'h0003EFFE, `RESP_OKAY);
		rd(`ADDR_LEVEL, 32'h000FFFFF, `RESP_OKAY);
		wr(`ADDR_LEVEL, 32'h000FFFFF, `RESP_OKAY);
		repeat (20) @(posedge aclk);
		wr(`ADDR_LEVEL, 32'h000FFFFF, `RESP_OKAY);
		repeat (20) @(posedge aclk);
		pins(20'h3FFFF, 20'h3FFFF);
		wr(8'h18, 32'h0, `RESP_SLVERR);
		rd(8'h1C, 32'h0, `RESP_SLVERR);
		reset_dut();
		pins(20'h0, 20'h0);
		finish_test();
	end
endmodule
`default_nettype wire
